// [verilog/dhp_pkg.sv]
// constants, pin bundle and bus states for the dual channel host bus port
// assumes a single core clock; pin levels are sampled into it by the port
package dhp_pkg;

  localparam int DHP_DATA_W = 8;
  localparam int DHP_ADDR_W = 3;
  localparam int DHP_CHANS = 2;
  localparam int DHP_DIRS = 2;
  localparam int DHP_FIFOS = DHP_CHANS * DHP_DIRS;
  localparam int DHP_FIFO_DEPTH = 64;
  localparam int DHP_DIR_TX = 0;
  localparam int DHP_DIR_RX = 1;

  // register offsets within one channel
  localparam logic [DHP_ADDR_W-1:0] DHP_OFS_HOLD = 3'h0;
  localparam logic [DHP_ADDR_W-1:0] DHP_OFS_CTRL = 3'h4;
  localparam logic [DHP_ADDR_W-1:0] DHP_OFS_STAT = 3'h5;
  localparam logic [DHP_ADDR_W-1:0] DHP_OFS_SCRATCH = 3'h7;

  // line_control_reg fields
  localparam int DHP_CTL_RX_IRQ_EN = 0;
  localparam int DHP_CTL_TX_IRQ_EN = 1;
  localparam int DHP_CTL_IRQ_OUT_EN = 3;
  localparam logic [DHP_DATA_W-1:0] DHP_CTL_RESET = 8'h00;

  // status register fields
  localparam int DHP_STAT_RX_AVAIL = 0;
  localparam int DHP_STAT_TX_ROOM = 5;
  localparam int DHP_STAT_TX_EMPTY = 6;

  localparam logic [DHP_DATA_W-1:0] DHP_UNMAPPED_VALUE = 8'h00;

  typedef enum logic [1:0] {
    DHP_IDLE = 2'b00,
    DHP_READ = 2'b01,
    DHP_WRITE = 2'b10
  } dhp_bus_state_t;

  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic csa_n;
    logic csb_n;
    logic [DHP_ADDR_W-1:0] addr;
    logic [DHP_DATA_W-1:0] data;
  } dhp_pins_t;

  localparam dhp_pins_t DHP_PINS_IDLE = '{rd_n: 1'b1, wr_n: 1'b1, csa_n: 1'b1, csb_n: 1'b1,
                                          addr: 3'h0, data: 8'h00};

endpackage

// [verilog/dhp_mem_if.sv]
// write and read port between the fifo control and one fifo storage
// assumes both ends run on the same core clock
interface dhp_mem_if #(
  parameter int W = 8,
  parameter int AW = 6
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// [verilog/dhp_fifo_ram.sv]
// storage for one fifo: one write port, one read port with registered data
// assumes the controller never reads and writes the same word expecting new data
module dhp_fifo_ram #(
  parameter int W = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic i_core_clk,
  dhp_mem_if.mem port
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] cells;
    logic [W-1:0] rd_data;
  } dhp_ram_state_t;

  dhp_ram_state_t state_reg;
  dhp_ram_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // read returns the old word on a same-address write
    state_next.rd_data = state_reg.cells[port.rd_addr];
    if (port.wr_en) begin
      state_next.cells[port.wr_addr] = port.wr_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    state_reg <= state_next;
  end

  assign port.rd_data = state_reg.rd_data;

endmodule

// [verilog/dhp_host_port.sv]
// host bus port of a dual serial channel controller with 64 byte fifos
// assumes asynchronous host strobes; the serial engines sit on the user side
//
// How it works
// - the three address lines pick one register of the selected channel for each transfer
// - bytes move over an eight bit two-way data bus, driven by the port during reads only
// - a falling read strobe starts a read and fetches the addressed register byte
// - the fetched byte stays on the data bus until the read strobe rises
// - a falling write strobe starts a write aimed at the addressed register
// - the data bus byte is stored into the addressed register when the write strobe rises
// - transfers reach channel A only while its select is held low
// - transfers reach channel B only while its select is held low
// - with channel A's output control bit set its interrupt pin is driven and its out2 pin is low
// - with that bit clear, the reset value, channel A's interrupt pin floats and its out2 pin is high
// - with channel B's output control bit set its interrupt pin is driven and its out2 pin is low
// - with that bit clear, the reset value, channel B's interrupt pin floats and its out2 pin is high
// - each channel has an active low transmit ready pin that shows room in its transmit fifo
// - each channel has an active low receive ready pin that shows data in its receive fifo
// - each channel buffers transmit and receive bytes in separate 64 byte fifos
module dhp_host_port import dhp_pkg::*; #(
  parameter int FIFO_DEPTH = DHP_FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [DHP_ADDR_W-1:0] i_reg_select_lines,
  input wire logic [DHP_DATA_W-1:0] i_data,
  output logic [DHP_DATA_W-1:0] o_data,
  output logic o_data_oe,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic i_chan_a_select_n,
  input wire logic i_chan_b_select_n,
  output logic o_chan_a_irq_out,
  output logic o_chan_a_irq_out_oe,
  output logic o_chan_a_general_out2_n,
  output logic o_chan_b_irq_out,
  output logic o_chan_b_irq_out_oe,
  output logic o_chan_b_general_out2_n,
  output logic o_chan_a_tx_ready_n,
  output logic o_chan_b_tx_ready_n,
  output logic o_chan_a_rx_ready_n,
  output logic o_chan_b_rx_ready_n,
  output logic [DHP_CHANS-1:0][DHP_DATA_W-1:0] o_tx_data,
  output logic [DHP_CHANS-1:0] o_tx_valid,
  input wire logic [DHP_CHANS-1:0] i_tx_taken,
  input wire logic [DHP_CHANS-1:0][DHP_DATA_W-1:0] i_rx_data,
  input wire logic [DHP_CHANS-1:0] i_rx_valid,
  output logic [DHP_CHANS-1:0] o_rx_space
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] head;
    logic [PTR_W-1:0] tail;
    logic [CNT_W-1:0] count;
    logic stale;
  } dhp_fifo_t;

  typedef struct packed {
    dhp_pins_t meta;
    dhp_pins_t sync;
    logic rd_prev;
    logic wr_prev;
    dhp_bus_state_t bus;
    logic chan;
    logic [DHP_ADDR_W-1:0] addr;
    logic [DHP_DATA_W-1:0] dout;
    logic dout_oe;
    dhp_fifo_t [DHP_FIFOS-1:0] fifo;
    logic [DHP_CHANS-1:0][DHP_DATA_W-1:0] ctl;
    logic [DHP_CHANS-1:0][DHP_DATA_W-1:0] scratch;
  } dhp_state_t;

  dhp_state_t state_reg;
  dhp_state_t state_next;
  dhp_pins_t pins_now;
  logic [DHP_FIFOS-1:0] push_req;
  logic [DHP_FIFOS-1:0] pop_req;
  logic [DHP_FIFOS-1:0] fifo_full;
  logic [DHP_FIFOS-1:0] fifo_avail;
  logic [DHP_FIFOS-1:0] fifo_empty;
  logic [DHP_FIFOS-1:0][DHP_DATA_W-1:0] ram_rd_data;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  logic one_select;
  logic [DHP_CHANS-1:0] irq_pending;
  logic [DHP_CHANS-1:0] irq_drive;
  logic [DHP_CHANS-1:0] tx_ready_n;
  logic [DHP_CHANS-1:0] rx_ready_n;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic int unsigned fifo_idx(input logic ch, input int dir);
    return int'(ch) * DHP_DIRS + dir;
  endfunction
  function automatic logic chan_selected(input dhp_pins_t p, input logic ch);
    return ch ? !p.csb_n : !p.csa_n;
  endfunction

  function automatic dhp_fifo_t fifo_next(input dhp_fifo_t f, input logic push, input logic pop);
    dhp_fifo_t n;
    logic push_ok;
    logic pop_ok;
    logic [CNT_W-1:0] left;
    n = f;
    push_ok = push && (f.count != CNT_FULL);
    pop_ok = pop && (f.count != '0);
    left = f.count - {{(CNT_W-1){1'b0}}, pop_ok};
    n.tail = f.tail + PTR_W'(push_ok);
    n.head = f.head + PTR_W'(pop_ok);
    n.count = left + {{(CNT_W-1){1'b0}}, push_ok};
    // head word written this cycle is not readable until the next
    n.stale = push_ok && (left == '0);
    return n;
  endfunction

  function automatic logic [DHP_DATA_W-1:0] reg_value(input logic ch, input logic [DHP_ADDR_W-1:0] a);
    logic [DHP_DATA_W-1:0] v;
    v = DHP_UNMAPPED_VALUE;
    case (a)
      DHP_OFS_HOLD: v = ram_rd_data[fifo_idx(ch, DHP_DIR_RX)];
      DHP_OFS_CTRL: v = state_reg.ctl[ch];
      DHP_OFS_STAT: begin
        v[DHP_STAT_RX_AVAIL] = fifo_avail[fifo_idx(ch, DHP_DIR_RX)];
        v[DHP_STAT_TX_ROOM] = !fifo_full[fifo_idx(ch, DHP_DIR_TX)];
        v[DHP_STAT_TX_EMPTY] = fifo_empty[fifo_idx(ch, DHP_DIR_TX)];
      end
      DHP_OFS_SCRATCH: v = state_reg.scratch[ch];
      default: v = DHP_UNMAPPED_VALUE;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // host bus sequencing

  assign pins_now = '{rd_n: i_read_strobe_n, wr_n: i_write_strobe_n, csa_n: i_chan_a_select_n,
                      csb_n: i_chan_b_select_n, addr: i_reg_select_lines, data: i_data};
  assign rd_fall = state_reg.rd_prev && !state_reg.sync.rd_n;
  assign rd_rise = !state_reg.rd_prev && state_reg.sync.rd_n;
  assign wr_fall = state_reg.wr_prev && !state_reg.sync.wr_n;
  assign wr_rise = !state_reg.wr_prev && state_reg.sync.wr_n;
  assign one_select = state_reg.sync.csa_n != state_reg.sync.csb_n;

  always_comb begin
    state_next = state_reg;
    push_req = '0;
    pop_req = '0;
    state_next.meta = pins_now;
    state_next.sync = state_reg.meta;
    state_next.rd_prev = state_reg.sync.rd_n;
    state_next.wr_prev = state_reg.sync.wr_n;
    case (state_reg.bus)
      DHP_IDLE: begin
        if (rd_fall && one_select) begin
          state_next.bus = DHP_READ;
          state_next.chan = state_reg.sync.csa_n;
          state_next.addr = state_reg.sync.addr;
          state_next.dout = reg_value(state_reg.sync.csa_n, state_reg.sync.addr);
          state_next.dout_oe = 1'b1;
        end else if (wr_fall && one_select) begin
          state_next.bus = DHP_WRITE;
          state_next.chan = state_reg.sync.csa_n;
          state_next.addr = state_reg.sync.addr;
        end
      end
      DHP_READ: begin
        if (!chan_selected(state_reg.sync, state_reg.chan)) begin
          state_next.bus = DHP_IDLE;
          state_next.dout_oe = 1'b0;
        end else if (rd_rise) begin
          state_next.bus = DHP_IDLE;
          state_next.dout_oe = 1'b0;
          pop_req[fifo_idx(state_reg.chan, DHP_DIR_RX)] = (state_reg.addr == DHP_OFS_HOLD);
        end
      end
      DHP_WRITE: begin
        if (!chan_selected(state_reg.sync, state_reg.chan)) begin
          state_next.bus = DHP_IDLE;
        end else if (wr_rise) begin
          state_next.bus = DHP_IDLE;
          case (state_reg.addr)
            DHP_OFS_HOLD: push_req[fifo_idx(state_reg.chan, DHP_DIR_TX)] = 1'b1;
            DHP_OFS_CTRL: state_next.ctl[state_reg.chan] = state_reg.sync.data;
            DHP_OFS_SCRATCH: state_next.scratch[state_reg.chan] = state_reg.sync.data;
            default: state_next.bus = DHP_IDLE;
          endcase
        end
      end
      default: begin
        state_next.bus = DHP_IDLE;
        state_next.dout_oe = 1'b0;
      end
    endcase
    for (int ch = 0; ch < DHP_CHANS; ch++) begin
      pop_req[ch * DHP_DIRS + DHP_DIR_TX] = o_tx_valid[ch] && i_tx_taken[ch];
      push_req[ch * DHP_DIRS + DHP_DIR_RX] = i_rx_valid[ch];
    end
    for (int f = 0; f < DHP_FIFOS; f++) begin
      state_next.fifo[f] = fifo_next(state_reg.fifo[f], push_req[f], pop_req[f]);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
      state_reg.meta <= DHP_PINS_IDLE;
      state_reg.sync <= DHP_PINS_IDLE;
      state_reg.rd_prev <= 1'b1;
      state_reg.wr_prev <= 1'b1;
      state_reg.bus <= DHP_IDLE;
      state_reg.ctl <= {DHP_CHANS{DHP_CTL_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_data = state_reg.dout;
  assign o_data_oe = state_reg.dout_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // fifo storage, one per direction and channel

  dhp_mem_if #(.W(DHP_DATA_W), .AW(PTR_W)) mem_bus [DHP_FIFOS] ();

  for (genvar g = 0; g < DHP_FIFOS; g++) begin : g_fifo
    localparam int CH = g / DHP_DIRS;
    localparam int IS_RX = g % DHP_DIRS;
    assign fifo_full[g] = state_reg.fifo[g].count == CNT_FULL;
    assign fifo_empty[g] = state_reg.fifo[g].count == '0;
    assign fifo_avail[g] = !fifo_empty[g] && !state_reg.fifo[g].stale;
    assign mem_bus[g].wr_en = push_req[g] && !fifo_full[g];
    assign mem_bus[g].wr_addr = state_reg.fifo[g].tail;
    assign mem_bus[g].wr_data = (IS_RX == DHP_DIR_RX) ? i_rx_data[CH] : state_reg.sync.data;
    assign mem_bus[g].rd_addr = state_next.fifo[g].head;
    assign ram_rd_data[g] = mem_bus[g].rd_data;
    dhp_fifo_ram #(.W(DHP_DATA_W), .DEPTH(FIFO_DEPTH), .AW(PTR_W)) u_ram (
      .i_core_clk(i_core_clk),
      .port(mem_bus[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per channel pins and user side

  for (genvar c = 0; c < DHP_CHANS; c++) begin : g_chan
    localparam int TXI = c * DHP_DIRS + DHP_DIR_TX;
    localparam int RXI = c * DHP_DIRS + DHP_DIR_RX;
    assign o_tx_valid[c] = fifo_avail[TXI];
    assign o_tx_data[c] = ram_rd_data[TXI];
    assign o_rx_space[c] = !fifo_full[RXI];
    assign tx_ready_n[c] = fifo_full[TXI];
    assign rx_ready_n[c] = !fifo_avail[RXI];
    assign irq_pending[c] = (state_reg.ctl[c][DHP_CTL_RX_IRQ_EN] && fifo_avail[RXI])
                          || (state_reg.ctl[c][DHP_CTL_TX_IRQ_EN] && fifo_empty[TXI]);
    assign irq_drive[c] = state_reg.ctl[c][DHP_CTL_IRQ_OUT_EN];
  end

  assign o_chan_a_irq_out = irq_drive[0] && irq_pending[0];
  assign o_chan_a_irq_out_oe = irq_drive[0];
  assign o_chan_a_general_out2_n = !irq_drive[0];
  assign o_chan_b_irq_out = irq_drive[1] && irq_pending[1];
  assign o_chan_b_irq_out_oe = irq_drive[1];
  assign o_chan_b_general_out2_n = !irq_drive[1];
  assign o_chan_a_tx_ready_n = tx_ready_n[0];
  assign o_chan_b_tx_ready_n = tx_ready_n[1];
  assign o_chan_a_rx_ready_n = rx_ready_n[0];
  assign o_chan_b_rx_ready_n = rx_ready_n[1];

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic start_ok;
  logic any_over;
  assign start_ok = (state_reg.bus == DHP_IDLE) && one_select;
  assign any_over = (state_reg.fifo[0].count > CNT_FULL) || (state_reg.fifo[1].count > CNT_FULL)
                  || (state_reg.fifo[2].count > CNT_FULL) || (state_reg.fifo[3].count > CNT_FULL);

  chk_addr_taken: assert property (start_ok && (rd_fall || wr_fall)
      |=> state_reg.addr == $past(state_reg.sync.addr))
    else $error("register address not taken at strobe start");
  chk_read_fetch: assert property (start_ok && rd_fall |=> state_reg.bus == DHP_READ && o_data_oe)
    else $error("read strobe fall did not start a fetch");
  chk_read_hold: assert property (state_reg.bus == DHP_READ && !rd_rise
      && chan_selected(state_reg.sync, state_reg.chan) |=> o_data_oe && $stable(o_data))
    else $error("read byte left the bus before the strobe rose");
  chk_write_start: assert property (start_ok && wr_fall && !rd_fall |=> state_reg.bus == DHP_WRITE)
    else $error("write strobe fall did not start a write");
  chk_write_store: assert property (state_reg.bus == DHP_WRITE && wr_rise
      && state_reg.addr == DHP_OFS_SCRATCH && chan_selected(state_reg.sync, state_reg.chan)
      |=> state_reg.scratch[$past(state_reg.chan)] == $past(state_reg.sync.data))
    else $error("write strobe rise did not store the byte");
  chk_chan_a_gate: assert property (state_reg.bus != DHP_IDLE && !state_reg.chan && state_reg.sync.csa_n
      |=> state_reg.bus == DHP_IDLE && !o_data_oe)
    else $error("channel a transfer went on without its select");
  chk_chan_b_gate: assert property (state_reg.bus != DHP_IDLE && state_reg.chan && state_reg.sync.csb_n
      |=> state_reg.bus == DHP_IDLE && !o_data_oe)
    else $error("channel b transfer went on without its select");
  chk_irq_a_mode: assert property (state_reg.bus == DHP_WRITE && wr_rise && !state_reg.chan
      && !state_reg.sync.csa_n && state_reg.addr == DHP_OFS_CTRL
      |=> o_chan_a_irq_out_oe == $past(state_reg.sync.data[DHP_CTL_IRQ_OUT_EN])
      && o_chan_a_general_out2_n != o_chan_a_irq_out_oe)
    else $error("channel a interrupt pin mode does not follow its control bit");
  chk_irq_a_float: assert property (!state_reg.ctl[0][DHP_CTL_IRQ_OUT_EN]
      |-> !o_chan_a_irq_out_oe && o_chan_a_general_out2_n && !o_chan_a_irq_out)
    else $error("channel a interrupt pin driven while disabled");
  chk_irq_b_mode: assert property (state_reg.bus == DHP_WRITE && wr_rise && state_reg.chan
      && !state_reg.sync.csb_n && state_reg.addr == DHP_OFS_CTRL
      |=> o_chan_b_irq_out_oe == $past(state_reg.sync.data[DHP_CTL_IRQ_OUT_EN])
      && o_chan_b_general_out2_n != o_chan_b_irq_out_oe)
    else $error("channel b interrupt pin mode does not follow its control bit");
  chk_irq_b_float: assert property (!state_reg.ctl[1][DHP_CTL_IRQ_OUT_EN]
      |-> !o_chan_b_irq_out_oe && o_chan_b_general_out2_n && !o_chan_b_irq_out)
    else $error("channel b interrupt pin driven while disabled");
  chk_tx_ready_full: assert property (state_reg.fifo[DHP_DIR_TX].count == CNT_FULL - 1'b1
      && push_req[DHP_DIR_TX] && !pop_req[DHP_DIR_TX] |=> o_chan_a_tx_ready_n)
    else $error("transmit ready stayed low with a full fifo");
  chk_rx_ready_fill: assert property (fifo_empty[DHP_DIR_RX] && i_rx_valid[0]
      |=> o_chan_a_rx_ready_n ##1 !o_chan_a_rx_ready_n)
    else $error("receive ready did not follow the first byte");
  chk_fifo_bound: assert property (!any_over)
    else $error("fifo level above its depth");

  cov_read_done: cover property (state_reg.bus == DHP_READ && rd_rise ##1 state_reg.bus == DHP_IDLE);
  cov_tx_push: cover property (state_reg.bus == DHP_WRITE && wr_rise && state_reg.addr == DHP_OFS_HOLD);
  cov_irq_b_on: cover property (o_chan_b_irq_out_oe && o_chan_b_irq_out);
  cov_rx_full: cover property (fifo_full[DHP_DIRS + DHP_DIR_RX]);

endmodule

// [verification/dhp_host_model.sv]
// host processor model driving the asynchronous byte bus of the port
// assumes the bench merges both data bus enables into i_bus
module dhp_host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_bus,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_csa_n,
  output logic o_csb_n,
  output logic [2:0] o_addr,
  output logic [7:0] o_data,
  output logic o_data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_csa_n = 1'b1;
    o_csb_n = 1'b1;
    o_addr = 3'h0;
    o_data = 8'h00;
    o_data_oe = 1'b0;
  end
  // ch 0 picks a, 1 picks b, 2 both at once
  task automatic xfer(input int ch, input logic rd, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge i_core_clk);
    o_csa_n = (ch == 1);
    o_csb_n = (ch == 0);
    o_addr = a;
    o_data = d;
    o_data_oe = !rd;
    repeat (4) @(negedge i_core_clk);
    if (rd) begin
      o_rd_n = 1'b0;
    end else begin
      o_wr_n = 1'b0;
    end
    repeat (8) @(negedge i_core_clk);
    q = i_bus;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    repeat (4) @(negedge i_core_clk);
    o_csa_n = 1'b1;
    o_csb_n = 1'b1;
    o_data_oe = 1'b0;
    o_addr = ~a;
    o_data = ~d;
    repeat (3) @(negedge i_core_clk);
  endtask
endmodule

// [verification/tb.sv]
// self-checking bench for the dual channel host bus port
// assumes the host model owns the bus pins; fifo sides driven here
module tb import dhp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DEPTH = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_n, wr_n, csa_n, csb_n, host_oe, o_data_oe;
  logic [2:0] addr;
  logic [7:0] host_d, o_data, bus, q;
  logic [1:0] irq, irq_oe, out2_n, txr_n, rxr_n, tx_valid, tx_taken, rx_valid, rx_space;
  logic [1:0][7:0] tx_data, rx_data;
  int error_cnt = 0;
  int total_checks = 0;
  always #2.5 clk = ~clk;
  // released bus shows the inverse of the last byte
  assign bus = o_data_oe ? o_data : (host_oe ? host_d : ~o_data);
  dhp_host_model i_host (.i_core_clk(clk), .i_bus(bus), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_csa_n(csa_n),
    .o_csb_n(csb_n), .o_addr(addr), .o_data(host_d), .o_data_oe(host_oe));
  dhp_host_port #(.FIFO_DEPTH(DEPTH)) i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_select_lines(addr),
    .i_data(bus), .o_data(o_data), .o_data_oe(o_data_oe), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
    .i_chan_a_select_n(csa_n), .i_chan_b_select_n(csb_n), .o_chan_a_irq_out(irq[0]),
    .o_chan_a_irq_out_oe(irq_oe[0]), .o_chan_a_general_out2_n(out2_n[0]), .o_chan_b_irq_out(irq[1]),
    .o_chan_b_irq_out_oe(irq_oe[1]), .o_chan_b_general_out2_n(out2_n[1]), .o_chan_a_tx_ready_n(txr_n[0]),
    .o_chan_b_tx_ready_n(txr_n[1]), .o_chan_a_rx_ready_n(rxr_n[0]), .o_chan_b_rx_ready_n(rxr_n[1]),
    .o_tx_data(tx_data), .o_tx_valid(tx_valid), .i_tx_taken(tx_taken), .i_rx_data(rx_data),
    .i_rx_valid(rx_valid), .o_rx_space(rx_space));
  ////////////////////////////////////////
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] d);
    i_host.xfer(ch, 1'b0, a, d, q);
  endtask
  task automatic rd_chk(input int ch, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] r;
    i_host.xfer(ch, 1'b1, a, 8'h00, r);
    chk_byte(r, exp);
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    for (int c = 0; c < 2; c++) begin
      chk_pin(irq_oe[c], 1'b0);
      chk_pin(out2_n[c], 1'b1);
      chk_pin(txr_n[c], 1'b0);
      chk_pin(rxr_n[c], 1'b1);
      chk_pin(tx_valid[c], 1'b0);
      chk_pin(rx_space[c], 1'b1);
    end
    chk_pin(o_data_oe, 1'b0);
  endtask
  task automatic t_irq_mode();
    for (int c = 0; c < 2; c++) begin
      wr(c, DHP_OFS_CTRL, 8'h08);
      chk_pin(irq_oe[c], 1'b1);
      chk_pin(out2_n[c], 1'b0);
      chk_pin(irq_oe[1-c], 1'b0);
      rd_chk(c, DHP_OFS_CTRL, 8'h08);
      wr(c, DHP_OFS_CTRL, 8'h0a);
      chk_pin(irq[c], 1'b1);
      wr(c, DHP_OFS_CTRL, 8'h02);
      chk_pin(irq_oe[c], 1'b0);
      chk_pin(out2_n[c], 1'b1);
      chk_pin(irq[c], 1'b0);
    end
  endtask
  task automatic t_scratch();
    wr(0, DHP_OFS_SCRATCH, 8'ha5);
    wr(1, DHP_OFS_SCRATCH, 8'h3c);
    wr(2, DHP_OFS_SCRATCH, 8'hff);
    rd_chk(0, DHP_OFS_SCRATCH, 8'ha5);
    rd_chk(1, DHP_OFS_SCRATCH, 8'h3c);
    rd_chk(0, 3'h1, 8'h00);
    rd_chk(1, DHP_OFS_STAT, 8'h60);
  endtask
  task automatic t_tx();
    for (int i = 0; i < DEPTH; i++) begin
      wr(0, DHP_OFS_HOLD, 8'h10 + 8'(i));
    end
    chk_pin(txr_n[0], 1'b1);
    chk_pin(txr_n[1], 1'b0);
    wr(0, DHP_OFS_HOLD, 8'hee);
    for (int i = 0; i < DEPTH; i++) begin
      chk_pin(tx_valid[0], 1'b1);
      chk_byte(tx_data[0], 8'h10 + 8'(i));
      tx_taken[0] = 1'b1;
      @(negedge clk);
      tx_taken[0] = 1'b0;
      @(negedge clk);
    end
    chk_pin(tx_valid[0], 1'b0);
    chk_pin(txr_n[0], 1'b0);
    wr(1, DHP_OFS_HOLD, 8'h77);
    chk_pin(tx_valid[1], 1'b1);
    chk_byte(tx_data[1], 8'h77);
    tx_taken[1] = 1'b1;
    @(negedge clk);
    tx_taken[1] = 1'b0;
    chk_pin(tx_valid[1], 1'b0);
  endtask
  task automatic t_rx();
    for (int i = 0; i < DEPTH; i++) begin
      rx_data[1] = 8'hc0 + 8'(i);
      rx_valid[1] = 1'b1;
      @(negedge clk);
    end
    rx_valid[1] = 1'b0;
    chk_pin(rx_space[1], 1'b0);
    @(negedge clk);
    chk_pin(rxr_n[1], 1'b0);
    chk_pin(rxr_n[0], 1'b1);
    for (int i = 0; i < DEPTH; i++) begin
      rd_chk(1, DHP_OFS_HOLD, 8'hc0 + 8'(i));
    end
    chk_pin(rxr_n[1], 1'b1);
    chk_pin(rx_space[1], 1'b1);
    // channel a: receive interrupt and the one stale cycle after a push into empty
    wr(0, DHP_OFS_CTRL, 8'h09);
    chk_pin(irq[0], 1'b0);
    rx_data[0] = 8'h5a;
    rx_valid[0] = 1'b1;
    @(negedge clk);
    rx_valid[0] = 1'b0;
    chk_pin(rxr_n[0], 1'b1);
    @(negedge clk);
    chk_pin(rxr_n[0], 1'b0);
    chk_pin(irq[0], 1'b1);
    rd_chk(0, DHP_OFS_STAT, 8'h61);
    rd_chk(0, DHP_OFS_HOLD, 8'h5a);
    chk_pin(rxr_n[0], 1'b1);
    chk_pin(irq[0], 1'b0);
  endtask
  ////////////////////////////////////////
  initial begin
    tx_taken = 2'b00;
    rx_valid = 2'b00;
    rx_data = '0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_irq_mode();
    t_scratch();
    t_tx();
    t_rx();
    end_sim();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
